// ===== ddrc_regs.vh
// Purpose: constants for the dual DAC register control block
// Assumes: 25 MHz ref_clk; serial clock sampled by ref_clk
// Notes: frame layout, power modes and reset values
// Behaviour
// - Power-up gives normal range and zero codes on both outputs.
// - Reset zeros input and DAC registers until first valid frame.
// - Clear low forces all input and DAC registers to zero.
// - Per-channel buffer select pin: high buffered, low unbuffered.
// - DAC codes are unsigned straight binary of the variant width.
// - Only DAC register content drives each converter tap.
// - Three per-channel power-down modes: 1k, 100k to ground, or high-Z.
// - Three-wire write port: frame select, serial clock, data in.
// - Load input high keeps DAC registers latched.
// - Load input low passes fresh codes straight to DAC registers.
// - Frame select high: ignore serial clock and data.
// - 16-bit MSB-first frame: channel, range, two mode bits, data.
// - Frame cut before 16th falling edge is discarded.
// - Power-down pin low forces both channels high-Z, keeps registers.
// - DAC register updates only if its input register was rewritten.
`ifndef DDRC_REGS_VH
`define DDRC_REGS_VH
`define DDRC_FRAME_BITS 16
`define DDRC_CNT_W 5
`define DDRC_BIT_CHAN 15
`define DDRC_BIT_RANGE 14
`define DDRC_BIT_PMHI 13
`define DDRC_BIT_PMLO 12
`define DDRC_DATA_MSB 11
`define DDRC_PM_NORMAL 2'h0
`define DDRC_PM_1K 2'h1
`define DDRC_PM_100K 2'h2
`define DDRC_PM_HIZ 2'h3
`define DDRC_RST_RANGE 1'h0
`define DDRC_RST_PM 2'h0
`endif

// ===== ddrc_fifo.v
// Purpose: small frame FIFO between serial capture and register update
// Assumes: single clock
// Notes: width and depth are parameters
`timescale 1ns/1ps
module ddrc_fifo #(
	parameter WIDTH = 16,
	parameter DEPTH = 8,
	parameter AW = 3
) (
	// Clock and reset
	input wire clk,
	input wire rst_n,
	input wire flush,
	// Fill side
	input wire in_valid,
	output wire in_ready,
	input wire [WIDTH-1:0] in_data,
	// Drain side
	output wire out_valid,
	input wire out_ready,
	output wire [WIDTH-1:0] out_data
);
	reg [WIDTH-1:0] mem [0:DEPTH-1];
	reg [AW-1:0] wr_ptr;
	reg [AW-1:0] rd_ptr;
	reg [AW:0] count;
	wire do_wr;
	wire do_rd;
	assign in_ready = (count != DEPTH[AW:0]);
	assign out_valid = (count != {(AW+1){1'b0}});
	assign out_data = mem[rd_ptr];
	assign do_wr = in_valid && in_ready;
	assign do_rd = out_valid && out_ready;
	always @(posedge clk)
	begin
		if (do_wr)
			mem[wr_ptr] <= in_data;
	end
	always @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			wr_ptr <= {AW{1'b0}};
			rd_ptr <= {AW{1'b0}};
			count <= {(AW+1){1'b0}};
		end
		else if (flush)
		begin
			wr_ptr <= {AW{1'b0}};
			rd_ptr <= {AW{1'b0}};
			count <= {(AW+1){1'b0}};
		end
		else
		begin
			if (do_wr)
				wr_ptr <= (wr_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_ptr + 1'b1;
			if (do_rd)
				rd_ptr <= (rd_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_ptr + 1'b1;
			if (do_wr && !do_rd)
				count <= count + 1'b1;
			else if (do_rd && !do_wr)
				count <= count - 1'b1;
		end
	end
endmodule // ddrc_fifo

// ===== ddrc_top.v
// Purpose: digital control of a dual voltage-output DAC
// Assumes: ref_clk 25 MHz oversamples the serial port pins
// Notes: serial clock must stay well below ref_clk/4 in practice
`timescale 1ns/1ps
`include "ddrc_regs.vh"
module ddrc_top #(
	parameter RES = 12
) (
	// Clock and reset
	input wire ref_clk,
	input wire resetn,
	// Serial write port
	input wire frame_sel_n,
	input wire serial_clk,
	input wire serial_din,
	// Control pins
	input wire load_outputs_n,
	input wire clear_all_n,
	input wire hw_powerdown_n,
	input wire buf_sel_a,
	input wire buf_sel_b,
	// Channel A outputs
	output reg [RES-1:0] code_a,
	output reg range_a,
	output reg [1:0] pmode_a,
	output reg ref_buf_a,
	output reg out_hiz_a,
	output reg out_pull_1k_a,
	output reg out_pull_100k_a,
	// Channel B outputs
	output reg [RES-1:0] code_b,
	output reg range_b,
	output reg [1:0] pmode_b,
	output reg ref_buf_b,
	output reg out_hiz_b,
	output reg out_pull_1k_b,
	output reg out_pull_100k_b,
	// Status
	output reg frame_error
);
	// Input register word: range, mode, code
	localparam IW = RES + 3;
	localparam ST_IDLE = 3'h1;
	localparam ST_SHIFT = 3'h2;
	localparam ST_DONE = 3'h4;

	reg rst_s1;
	reg rst_n;
	reg [2:0] fs_sync;
	reg [2:0] sc_sync;
	reg [1:0] ld_sync;
	reg [1:0] clear_sync;
	reg [1:0] pwrdn_sync;
	reg [1:0] bufa_sync;
	reg [1:0] bufb_sync;
	reg [1:0] din_sync;
	reg [2:0] state;
	reg [2:0] next_state;
	reg [`DDRC_FRAME_BITS-1:0] shreg;
	reg [`DDRC_CNT_W-1:0] bit_cnt;
	reg [IW-1:0] inreg_a;
	reg [IW-1:0] inreg_b;
	reg [IW-1:0] dacreg_a;
	reg [IW-1:0] dacreg_b;
	reg fresh_a;
	reg fresh_b;
	wire clear_now;
	wire sc_fall;
	wire fs_low;
	wire fs_rise;
	wire ld_low;
	wire q_valid;
	wire q_ready;
	wire [`DDRC_FRAME_BITS-1:0] q_data;
	wire q_in_ready;
	wire push;
	wire [IW-1:0] q_word;

	// Upper bits of the data field form the code
	function [IW-1:0] ddrc_pack;
		input [`DDRC_FRAME_BITS-1:0] f;
		begin
			ddrc_pack = {f[`DDRC_BIT_RANGE], f[`DDRC_BIT_PMHI], f[`DDRC_BIT_PMLO],
				f[`DDRC_DATA_MSB -: RES]};
		end
	endfunction

	// Reset release
	always @(posedge ref_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			rst_s1 <= 1'b0;
			rst_n <= 1'b0;
		end
		else
		begin
			rst_s1 <= 1'b1;
			rst_n <= rst_s1;
		end
	end

	// Synced copy flushes the queue; the banks clear on the raw pin
	assign clear_now = !clear_sync[1];

	always @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			fs_sync <= 3'h7;
			sc_sync <= 3'h7;
			ld_sync <= 2'h3;
			clear_sync <= 2'h3;
			pwrdn_sync <= 2'h3;
			bufa_sync <= 2'h0;
			bufb_sync <= 2'h0;
			din_sync <= 2'h0;
		end
		else
		begin
			fs_sync <= {fs_sync[1:0], frame_sel_n};
			sc_sync <= {sc_sync[1:0], serial_clk};
			ld_sync <= {ld_sync[0], load_outputs_n};
			clear_sync <= {clear_sync[0], clear_all_n};
			pwrdn_sync <= {pwrdn_sync[0], hw_powerdown_n};
			bufa_sync <= {bufa_sync[0], buf_sel_a};
			bufb_sync <= {bufb_sync[0], buf_sel_b};
			din_sync <= {din_sync[0], serial_din};
		end
	end

	assign sc_fall = sc_sync[2] && !sc_sync[1];
	assign fs_low = !fs_sync[1];
	assign fs_rise = !fs_sync[2] && fs_sync[1];
	assign ld_low = !ld_sync[1];

	// Frame capture
	always @*
	begin
		next_state = state;
		case (state)
			ST_IDLE:
				if (fs_low)
					next_state = ST_SHIFT;
			ST_SHIFT:
				if (fs_rise)
					next_state = ST_IDLE;
				else if (sc_fall && bit_cnt == (`DDRC_FRAME_BITS - 1))
					next_state = ST_DONE;
			ST_DONE:
				if (fs_rise)
					next_state = ST_IDLE;
			default:
				next_state = ST_IDLE;
		endcase
	end

	assign push = (state == ST_SHIFT) && !fs_rise && sc_fall &&
		(bit_cnt == (`DDRC_FRAME_BITS - 1));

	always @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			state <= ST_IDLE;
			shreg <= {`DDRC_FRAME_BITS{1'b0}};
			bit_cnt <= {`DDRC_CNT_W{1'b0}};
			frame_error <= 1'b0;
		end
		else
		begin
			state <= next_state;
			if (state == ST_IDLE)
				bit_cnt <= {`DDRC_CNT_W{1'b0}};
			else if (state == ST_SHIFT && sc_fall && !fs_rise)
			begin
				shreg <= {shreg[`DDRC_FRAME_BITS-2:0], din_sync[1]};
				bit_cnt <= bit_cnt + 1'b1;
			end
			if (push && !q_in_ready)
				frame_error <= 1'b1;
			else if (state == ST_SHIFT && fs_rise)
				frame_error <= 1'b1;
			else if (push)
				frame_error <= 1'b0;
		end
	end

	ddrc_fifo #(
		.WIDTH(`DDRC_FRAME_BITS),
		.DEPTH(8),
		.AW(3)
	) ddrc_fifo_inst (
		.clk(ref_clk),
		.rst_n(rst_n),
		.flush(clear_now),
		.in_valid(push),
		.in_ready(q_in_ready),
		.in_data({shreg[`DDRC_FRAME_BITS-2:0], din_sync[1]}),
		.out_valid(q_valid),
		.out_ready(q_ready),
		.out_data(q_data)
	);

	// One frame drained per cycle
	assign q_ready = !clear_now;
	assign q_word = ddrc_pack(q_data);

	// Input and DAC register banks
	always @(posedge ref_clk or negedge rst_n or negedge clear_all_n)
	begin
		if (!rst_n || !clear_all_n)
		begin
			inreg_a <= {IW{1'b0}};
			inreg_b <= {IW{1'b0}};
			dacreg_a <= {IW{1'b0}};
			dacreg_b <= {IW{1'b0}};
			fresh_a <= 1'b0;
			fresh_b <= 1'b0;
		end
		else if (!clear_sync[1])
		begin
			inreg_a <= {IW{1'b0}};
			inreg_b <= {IW{1'b0}};
			dacreg_a <= {IW{1'b0}};
			dacreg_b <= {IW{1'b0}};
			fresh_a <= 1'b0;
			fresh_b <= 1'b0;
		end
		else
		begin
			if (q_valid && !q_data[`DDRC_BIT_CHAN])
			begin
				inreg_a <= q_word;
				fresh_a <= !ld_low;
				if (ld_low)
					dacreg_a <= q_word;
			end
			else if (ld_low && fresh_a)
			begin
				dacreg_a <= inreg_a;
				fresh_a <= 1'b0;
			end
			if (q_valid && q_data[`DDRC_BIT_CHAN])
			begin
				inreg_b <= q_word;
				fresh_b <= !ld_low;
				if (ld_low)
					dacreg_b <= q_word;
			end
			else if (ld_low && fresh_b)
			begin
				dacreg_b <= inreg_b;
				fresh_b <= 1'b0;
			end
		end
	end

	// Output stage drive from DAC registers, buffer select pins and power-down pin
	always @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			code_a <= {RES{1'b0}};
			code_b <= {RES{1'b0}};
			range_a <= `DDRC_RST_RANGE;
			range_b <= `DDRC_RST_RANGE;
			pmode_a <= `DDRC_RST_PM;
			pmode_b <= `DDRC_RST_PM;
			ref_buf_a <= 1'b0;
			ref_buf_b <= 1'b0;
			out_hiz_a <= 1'b0;
			out_hiz_b <= 1'b0;
			out_pull_1k_a <= 1'b0;
			out_pull_1k_b <= 1'b0;
			out_pull_100k_a <= 1'b0;
			out_pull_100k_b <= 1'b0;
		end
		else
		begin
			code_a <= dacreg_a[RES-1:0];
			code_b <= dacreg_b[RES-1:0];
			range_a <= dacreg_a[RES+2];
			range_b <= dacreg_b[RES+2];
			pmode_a <= dacreg_a[RES+1:RES];
			pmode_b <= dacreg_b[RES+1:RES];
			ref_buf_a <= bufa_sync[1];
			ref_buf_b <= bufb_sync[1];
			out_hiz_a <= !pwrdn_sync[1] || dacreg_a[RES+1:RES] == `DDRC_PM_HIZ;
			out_hiz_b <= !pwrdn_sync[1] || dacreg_b[RES+1:RES] == `DDRC_PM_HIZ;
			out_pull_1k_a <= pwrdn_sync[1] && dacreg_a[RES+1:RES] == `DDRC_PM_1K;
			out_pull_1k_b <= pwrdn_sync[1] && dacreg_b[RES+1:RES] == `DDRC_PM_1K;
			out_pull_100k_a <= pwrdn_sync[1] && dacreg_a[RES+1:RES] == `DDRC_PM_100K;
			out_pull_100k_b <= pwrdn_sync[1] && dacreg_b[RES+1:RES] == `DDRC_PM_100K;
		end
	end
endmodule // ddrc_top

// ===== ddrc_checker_sva.sv
// Purpose: checker for ddrc_top
// Assumes: one clock domain
// Notes: bound at file foot
`timescale 1ns/1ps
module ddrc_checker #(
	parameter RES = 12
) (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic resetn,
	// Control pins
	input wire logic load_outputs_n,
	input wire logic clear_all_n,
	input wire logic hw_powerdown_n,
	input wire logic buf_sel_a,
	// Outputs
	input wire logic [RES-1:0] code_a,
	input wire logic [RES-1:0] code_b,
	input wire logic [1:0] pmode_a,
	input wire logic [1:0] pmode_b,
	input wire logic ref_buf_a,
	input wire logic out_hiz_a,
	input wire logic out_hiz_b,
	input wire logic out_pull_1k_a
);
	default clocking @(posedge ref_clk);
	endclocking
	default disable iff (!resetn);
	sequence s_latched;
		(load_outputs_n && clear_all_n)[*8];
	endsequence
	sequence s_run_a;
		(hw_powerdown_n && $stable(pmode_a))[*6];
	endsequence
	sequence s_run_b;
		(hw_powerdown_n && $stable(pmode_b))[*6];
	endsequence
	AST_CLEAR_A: assert property (!clear_all_n |-> ##[0:3] code_a == '0)
		else $error("code_a not cleared");
	AST_CLEAR_WINS: assert property ((!clear_all_n)[*4] |-> code_b == '0)
		else $error("code_b moved under clear");
	AST_HOLD: assert property (s_latched |=> $stable(code_a) && $stable(code_b))
		else $error("code moved while latched");
	AST_HW_POWERDOWN: assert property ((!hw_powerdown_n)[*6] |-> out_hiz_a && out_hiz_b)
		else $error("outputs not high-Z");
	AST_HIZ_A: assert property (s_run_a |-> out_hiz_a == (pmode_a == 2'h3))
		else $error("high-Z A wrong");
	AST_PULL_A: assert property (s_run_a |-> out_pull_1k_a == (pmode_a == 2'h1))
		else $error("1k pull A wrong");
	AST_HIZ_B: assert property (s_run_b |-> out_hiz_b == (pmode_b == 2'h3))
		else $error("high-Z B wrong");
	AST_BUF_A: assert property ($stable(buf_sel_a)[*6] |-> ref_buf_a == buf_sel_a)
		else $error("buffer select A wrong");
endmodule // ddrc_checker

bind ddrc_top ddrc_checker #(.RES(RES)) ddrc_checker_inst (
	.ref_clk(ref_clk), .resetn(resetn), .load_outputs_n(load_outputs_n),
	.clear_all_n(clear_all_n), .hw_powerdown_n(hw_powerdown_n), .buf_sel_a(buf_sel_a),
	.code_a(code_a), .code_b(code_b), .pmode_a(pmode_a), .pmode_b(pmode_b),
	.ref_buf_a(ref_buf_a), .out_hiz_a(out_hiz_a), .out_hiz_b(out_hiz_b),
	.out_pull_1k_a(out_pull_1k_a)
);

// ===== ddrc_host_model.sv
// Purpose: host serial port model
// Assumes: 320 ns serial clock, idle high
// Notes: a short bit count aborts the frame
`timescale 1ns/1ps
module ddrc_host_model (
	// Serial write port
	output logic frame_sel_n,
	output logic serial_clk,
	output logic serial_din
);
	initial
	begin
		frame_sel_n = 1'b1;
		serial_clk = 1'b1;
		serial_din = 1'b0;
	end
	task automatic send(input logic [15:0] word, input int nbits);
		int i;
		frame_sel_n = 1'b0;
		#320;
		for (i = 0; i < nbits; i++)
		begin
			serial_din = word[15-i];
			#160 serial_clk = 1'b0;
			#160 serial_clk = 1'b1;
		end
		#160 frame_sel_n = 1'b1;
		serial_din = ~serial_din;
		#320;
	endtask
endmodule // ddrc_host_model

// ===== ddrc_top_tb_top.sv
// Purpose: bench for ddrc_top
// Assumes: RES of 12
// Notes: pins change at falling ref_clk
`timescale 1ns/1ps
module ddrc_top_tb_top;
	logic ref_clk = 1'b0, resetn = 1'b0, ld_n = 1'b1, clear_n = 1'b1, pwrdn_n = 1'b1;
	logic bs_a = 1'b0, bs_b = 1'b0, fs_n, sck, sdi, f_err;
	logic range_a, range_b, buf_a, buf_b, hiz_a, hiz_b, k1_a, k1_b, k100_a, k100_b;
	logic [11:0] code_a, code_b;
	logic [1:0] pm_a, pm_b;
	int bad_count = 0, tests_run = 0, cycles = 0, i;
	always #20 ref_clk = ~ref_clk;
	ddrc_host_model ddrc_host_model_inst (.frame_sel_n(fs_n), .serial_clk(sck), .serial_din(sdi));
	ddrc_top #(.RES(12)) ddrc_top_inst (
		.ref_clk(ref_clk), .resetn(resetn), .frame_sel_n(fs_n), .serial_clk(sck),
		.serial_din(sdi), .load_outputs_n(ld_n), .clear_all_n(clear_n),
		.hw_powerdown_n(pwrdn_n), .buf_sel_a(bs_a), .buf_sel_b(bs_b),
		.code_a(code_a), .range_a(range_a), .pmode_a(pm_a), .ref_buf_a(buf_a),
		.out_hiz_a(hiz_a), .out_pull_1k_a(k1_a), .out_pull_100k_a(k100_a),
		.code_b(code_b), .range_b(range_b), .pmode_b(pm_b), .ref_buf_b(buf_b),
		.out_hiz_b(hiz_b), .out_pull_1k_b(k1_b), .out_pull_100k_b(k100_b),
		.frame_error(f_err)
	);
	task automatic print_verdict;
		if (bad_count == 0 && tests_run > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		tests_run++;
		if (seen !== exp)
		begin
			bad_count++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic idle;
		repeat (8) @(negedge ref_clk);
	endtask
	task automatic wr(input logic [15:0] w, input int n);
		@(negedge ref_clk);
		ddrc_host_model_inst.send(w, n);
		idle();
	endtask
	always @(posedge ref_clk)
	begin
		cycles++;
		if (cycles == 8000)
		begin
			bad_count++;
			print_verdict();
		end
	end
	initial
	begin
		repeat (16) @(posedge ref_clk);
		@(negedge ref_clk);
		resetn = 1'b1;
		idle();
		check({range_a, pm_a, code_a}, 16'h0);
		check({range_b, pm_b, code_b}, 16'h0);
		wr(16'h4ABC, 16);
		wr(16'h8123, 16);
		check(code_a, 16'h0);
		ld_n = 1'b0;
		idle();
		ld_n = 1'b1;
		idle();
		check({range_a, code_a}, 16'h1ABC);
		check(code_b, 16'h123);
		ld_n = 1'b0;
		for (i = 0; i < 4; i++)
		begin
			wr({2'b10, i[1:0], 12'h5A5}, 16);
			check(code_b, 16'h5A5);
			check(pm_b, i[1:0]);
			check({hiz_b, k100_b, k1_b}, 16'(i ? 1 << (i - 1) : 0));
		end
		wr(16'h0FFF, 10);
		check({f_err, code_a}, 16'h1ABC);
		wr(16'h0321, 16);
		check({f_err, code_a}, 16'h0321);
		wr(16'h2321, 16);
		check({hiz_a, k100_a, k1_a, pm_a}, 16'hA);
		pwrdn_n = 1'b0;
		idle();
		check({hiz_a, hiz_b, k100_a, k1_a, code_a}, 16'hC321);
		pwrdn_n = 1'b1;
		bs_a = 1'b1;
		idle();
		check({buf_a, buf_b}, 16'h2);
		bs_a = 1'b0;
		bs_b = 1'b1;
		idle();
		check({buf_a, buf_b}, 16'h1);
		clear_n = 1'b0;
		wr(16'h0FFF, 16);
		check(code_a, 16'h0);
		check(code_b, 16'h0);
		clear_n = 1'b1;
		idle();
		check(code_a, 16'h0);
		print_verdict();
	end
endmodule // ddrc_top_tb_top
